// file: design/gdp_pkg.sv
package gdp_pkg;
   // Clock and bus timing.
   localparam int CLK_MHZ       = 200;
   localparam int T_SETTLE_NS   = 2000;
   localparam int SETTLE_CYC    = (T_SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int T_FLASH_MS    = 100;
   localparam int FLASH_CYC     = T_FLASH_MS * CLK_MHZ * 1000;
   localparam int SW_SETTLE_CYC = 4;

   // Address switches and defaults.
   localparam logic [4:0] ADDR_DEFAULT = 5'h06;
   localparam logic [4:0] ADDR_CTRL    = 5'h00;

   // Register byte offsets on the Wishbone slave.
   localparam logic [7:0] A_STAT  = 8'h00;
   localparam logic [7:0] A_TXD   = 8'h04;
   localparam logic [7:0] A_DSTAT = 8'h08;
   localparam logic [7:0] A_STB   = 8'h0c;
   localparam int         A_SLOT_BIT = 7;
   localparam int         TXD_EOI = 8;

   // Status byte bits.
   localparam int STB_RSV = 6;
   localparam int STB_ERR = 0;

   // Bus commands sent under attention, seven bits.
   localparam logic [6:0] CMD_GTL = 7'h01;
   localparam logic [6:0] CMD_SDC = 7'h04;
   localparam logic [6:0] CMD_GET = 7'h08;
   localparam logic [6:0] CMD_LLO = 7'h11;
   localparam logic [6:0] CMD_DCL = 7'h14;
   localparam logic [6:0] CMD_SPE = 7'h18;
   localparam logic [6:0] CMD_SPD = 7'h19;
   localparam logic [6:0] CMD_UNL = 7'h3f;
   localparam logic [1:0] GRP_LISTEN = 2'h1;
   localparam logic [1:0] GRP_TALK   = 2'h2;

   // Command parser characters and categories.
   localparam int          NUM_CAT   = 26;
   localparam logic [25:0] CAT_VALID = 26'h3ffffff;
   localparam logic [7:0]  CH_A      = 8'h41;
   localparam logic [7:0]  CH_Z      = 8'h5a;
   localparam logic [7:0]  CH_LA     = 8'h61;
   localparam logic [7:0]  CH_LZ     = 8'h7a;
   localparam logic [7:0]  CH_CASE   = 8'h20;
   localparam logic [7:0]  CH_CR     = 8'h0d;
   localparam logic [7:0]  CH_LF     = 8'h0a;
   localparam logic [7:0]  CH_SP     = 8'h20;

   // Synchroniser vector layout (all bits true-level).
   localparam int P_DIO = 0;
   localparam int P_SW  = 8;
   localparam int P_DAV = 16;
   localparam int P_RFD = 17;
   localparam int P_DAC = 18;
   localparam int P_EOI = 19;
   localparam int P_ATN = 20;
   localparam int P_IFC = 21;
   localparam int P_REN = 22;
   localparam int P_BTN = 23;
   localparam int NPIN  = 24;

   typedef enum logic [2:0] {AH_IDLE = 3'b001, AH_READY = 3'b010, AH_HOLD = 3'b100} gdp_ah_e;
   typedef enum logic [3:0] {SH_IDLE = 4'b0001, SH_SETTLE = 4'b0010, SH_WAIT = 4'b0100, SH_DAV = 4'b1000} gdp_sh_e;
   typedef enum logic [3:0] {TO_IDLE = 4'b0001, TO_MEAS = 4'b0010, TO_SEND = 4'b0100, TO_FLASH = 4'b1000} gdp_to_e;
endpackage

// file: design/gdp_port.sv
`timescale 1ns/10ps
// What this block does
// - Switch one on gives addressable, controller-driven operation.
// - Address is sum of OFF switches 4-8.
// - Default address six; address zero never used.
// - Switch one off at power-up: talker-only, talk lit.
// - Talker-only: press measures, sends, flashes listen.
// - Invalid command not executed; error bit set.
// - Command letters accepted in either case.
// - One slot per category; last one wins.
// - Full source handshake when sending bytes.
// - Full acceptor handshake when receiving bytes.
// - Drive data only when talk-addressed or talker-only.
// - Accept device data only when listen-addressed.
// - Can request service on the request line.
// - No parallel poll response.
// - Remote and local; remote indicator while remote.
// - Device clear restores default settings.
// - Bus trigger starts a measurement.
// - No controller, primary addressing only.
// - Listen lit receiving, talk lit transmitting.
// - Lockout disables buttons and lights indicator.
// - Reading detailed status clears error bit.
module gdp_port #(
   parameter int FLASH_CYCLES = gdp_pkg::FLASH_CYC
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        wb_cyc,
   input  wire logic        wb_stb,
   input  wire logic        wb_we,
   input  wire logic [7:0]  wb_adr,
   input  wire logic [3:0]  wb_sel,
   input  wire logic [31:0] wb_dat_w,
   output logic      [31:0] wb_dat_r,
   output logic             wb_ack,
   input  wire logic [7:0]  dio_in,
   output logic      [7:0]  dio_out,
   output logic      [7:0]  dio_oe,
   input  wire logic        dav_n_in,
   output logic             dav_n_out,
   output logic             dav_n_oe,
   input  wire logic        nrfd_n_in,
   output logic             nrfd_n_out,
   output logic             nrfd_n_oe,
   input  wire logic        ndac_n_in,
   output logic             ndac_n_out,
   output logic             ndac_n_oe,
   input  wire logic        eoi_n_in,
   output logic             eoi_n_out,
   output logic             eoi_n_oe,
   input  wire logic        atn_n,
   input  wire logic        ifc_n,
   input  wire logic        ren_n,
   output logic             srq_n_out,
   output logic             srq_n_oe,
   input  wire logic [7:0]  cfg_sw,
   input  wire logic        button,
   output logic             meas_start,
   input  wire logic        meas_done,
   input  wire logic [7:0]  meas_data,
   output logic             led_remote,
   output logic             led_listen,
   output logic             led_talk,
   output logic             led_lockout,
   output logic             btn_enable
);
   import gdp_pkg::*;

   logic [NPIN-1:0] s1_ff, s2_ff, s3_ff, pin_ff;
   logic [2:0]      sw_cnt_ff;
   logic            cfg_done_ff, to_mode_ff;
   logic [4:0]      addr_ff;
   gdp_ah_e         ah_ff;
   gdp_sh_e         sh_ff;
   gdp_to_e         to_ff;
   logic [7:0]      rx_byte_ff;
   logic            rx_stb_ff, rx_atn_ff, rx_eoi_ff;
   logic            lad_ff, tad_ff, spe_ff, remote_ff, lockout_ff;
   logic [8:0]      settle_ff;
   logic [7:0]      tx_byte_ff;
   logic            tx_eoi_ff, tx_pend_ff, tx_poll_ff;
   logic [24:0]     flash_ff;
   logic            btn_prev_ff, meas_start_ff;
   logic [6:0]      stb_ff;
   logic [7:0]      err_char_ff;
   logic            phase_ff;
   logic [4:0]      cat_ff;
   logic [7:0]      slot_ff [NUM_CAT];
   logic            ack_ff;
   logic [31:0]     dat_r_ff;
   logic [31:0]     nxt_dat_r;

   logic dav_s, rfd_s, dac_s, atn_s, ifc_s, ren_s;
   logic [4:0] sw_addr;
   assign dav_s   = pin_ff[P_DAV];
   assign rfd_s   = pin_ff[P_RFD];
   assign dac_s   = pin_ff[P_DAC];
   assign atn_s   = pin_ff[P_ATN];
   assign ifc_s   = pin_ff[P_IFC];
   assign ren_s   = pin_ff[P_REN];
   assign sw_addr = ~{pin_ff[P_SW+3], pin_ff[P_SW+4], pin_ff[P_SW+5], pin_ff[P_SW+6], pin_ff[P_SW+7]};

   // Three-stage pin synchroniser; a bit changes once stages two and three agree.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff  <= '0;
         s2_ff  <= '0;
         s3_ff  <= '0;
         pin_ff <= '0;
      end else begin
         s1_ff  <= {button, ~ren_n, ~ifc_n, ~atn_n, ~eoi_n_in, ~ndac_n_in, ~nrfd_n_in, ~dav_n_in, cfg_sw, ~dio_in};
         s2_ff  <= s1_ff;
         s3_ff  <= s2_ff;
         pin_ff <= (s2_ff & s3_ff) | (pin_ff & (s2_ff | s3_ff));
      end
   end

   // Mode and address are captured once after the synchroniser settles.
   // The filtered bits lag the third stage by one cycle, so the count covers four edges.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sw_cnt_ff   <= '0;
         cfg_done_ff <= 1'b0;
         to_mode_ff  <= 1'b0;
         addr_ff     <= ADDR_DEFAULT;
      end else if (!cfg_done_ff) begin
         sw_cnt_ff <= sw_cnt_ff + 3'h1;
         if (sw_cnt_ff == 3'(SW_SETTLE_CYC)) begin
            cfg_done_ff <= 1'b1;
            to_mode_ff  <= ~pin_ff[P_SW];
            addr_ff     <= (sw_addr == ADDR_CTRL) ? ADDR_DEFAULT : sw_addr;
         end
      end
   end

   // Acceptor takes part during attention or when listen-addressed.
   logic ah_act;
   assign ah_act = cfg_done_ff & ~to_mode_ff & (atn_s | lad_ff) & (sh_ff == SH_IDLE);

   // Acceptor handshake; a byte is latched when data valid is seen ready.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ah_ff      <= AH_IDLE;
         rx_byte_ff <= '0;
         rx_stb_ff  <= 1'b0;
         rx_atn_ff  <= 1'b0;
         rx_eoi_ff  <= 1'b0;
      end else begin
         rx_stb_ff <= 1'b0;
         case (ah_ff)
            AH_IDLE: if (ah_act && !dav_s) ah_ff <= AH_READY;
            AH_READY: begin
               if (!ah_act) begin
                  ah_ff <= AH_IDLE;
               end else if (dav_s) begin
                  ah_ff      <= AH_HOLD;
                  rx_byte_ff <= pin_ff[P_DIO+:8];
                  rx_atn_ff  <= atn_s;
                  rx_eoi_ff  <= pin_ff[P_EOI];
                  rx_stb_ff  <= 1'b1;
               end
            end
            AH_HOLD: if (!dav_s) ah_ff <= AH_READY;
            default: ah_ff <= AH_IDLE;
         endcase
      end
   end

   // Command decode; primary addressing only, nothing extended.
   logic [6:0] cmd;
   logic atn_cmd, is_mla, is_mta, is_unl, is_ota, dat_stb, dev_clr, got_get;
   assign cmd     = rx_byte_ff[6:0];
   assign atn_cmd = rx_stb_ff & rx_atn_ff & ~to_mode_ff;
   assign is_mla  = atn_cmd & (cmd == {GRP_LISTEN, addr_ff});
   assign is_mta  = atn_cmd & (cmd == {GRP_TALK, addr_ff});
   assign is_unl  = atn_cmd & (cmd == CMD_UNL);
   assign is_ota  = atn_cmd & (cmd[6:5] == GRP_TALK) & ~is_mta;
   assign dat_stb = rx_stb_ff & ~rx_atn_ff & lad_ff;
   assign dev_clr = (atn_cmd & (cmd == CMD_DCL)) | (atn_cmd & lad_ff & (cmd == CMD_SDC));
   assign got_get = atn_cmd & lad_ff & (cmd == CMD_GET);

   // Listen and talk address state; interface clear drops both.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         lad_ff <= 1'b0;
         tad_ff <= 1'b0;
         spe_ff <= 1'b0;
      end else if (ifc_s) begin
         lad_ff <= 1'b0;
         tad_ff <= 1'b0;
         spe_ff <= 1'b0;
      end else begin
         if (is_mla) lad_ff <= 1'b1;
         else if (is_unl) lad_ff <= 1'b0;
         if (is_mta) tad_ff <= 1'b1;
         else if (is_ota) tad_ff <= 1'b0;
         if (atn_cmd && cmd == CMD_SPE) spe_ff <= 1'b1;
         else if (atn_cmd && cmd == CMD_SPD) spe_ff <= 1'b0;
      end
   end

   // Remote and lockout follow the remote enable line.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         remote_ff  <= 1'b0;
         lockout_ff <= 1'b0;
      end else if (!ren_s) begin
         remote_ff  <= 1'b0;
         lockout_ff <= 1'b0;
      end else begin
         if (is_mla) remote_ff <= 1'b1;
         else if (atn_cmd && lad_ff && cmd == CMD_GTL) remote_ff <= 1'b0;
         if (atn_cmd && cmd == CMD_LLO) lockout_ff <= 1'b1;
      end
   end

   // Parser: category letter then option, either case, one slot per category.
   logic [7:0] lc;
   logic [7:0] cat_off;
   logic is_let, is_sep, parse_err;
   assign lc        = (rx_byte_ff >= CH_A && rx_byte_ff <= CH_Z) ? (rx_byte_ff | CH_CASE) : rx_byte_ff;
   assign is_let    = (lc >= CH_LA) && (lc <= CH_LZ);
   assign cat_off   = lc - CH_LA;
   assign is_sep    = (lc == CH_CR) || (lc == CH_LF) || (lc == CH_SP);
   assign parse_err = dat_stb & ~phase_ff & ~is_sep & ~(is_let && CAT_VALID[cat_off[4:0]]);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         phase_ff    <= 1'b0;
         cat_ff      <= '0;
         err_char_ff <= '0;
         for (int i = 0; i < NUM_CAT; i++) slot_ff[i] <= '0;
      end else if (dev_clr) begin
         phase_ff <= 1'b0;
         for (int i = 0; i < NUM_CAT; i++) slot_ff[i] <= '0;
      end else if (dat_stb) begin
         if (parse_err) begin
            err_char_ff <= rx_byte_ff;
         end else if (!phase_ff && !is_sep) begin
            cat_ff   <= cat_off[4:0];
            phase_ff <= ~rx_eoi_ff;
         end else if (phase_ff) begin
            slot_ff[cat_ff] <= lc;
            phase_ff        <= 1'b0;
         end
      end
   end

   // Talker-only sequence: press, measure, send, flash listen.
   logic btn_rise, talk_ok, tx_done;
   assign btn_rise = pin_ff[P_BTN] & ~btn_prev_ff & ~lockout_ff;
   assign talk_ok  = to_mode_ff | (tad_ff & ~atn_s);
   assign tx_done  = (sh_ff == SH_DAV) & ~dac_s;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         to_ff         <= TO_IDLE;
         flash_ff      <= '0;
         btn_prev_ff   <= 1'b0;
         meas_start_ff <= 1'b0;
      end else begin
         btn_prev_ff   <= pin_ff[P_BTN];
         meas_start_ff <= got_get | (to_mode_ff & (to_ff == TO_IDLE) & btn_rise);
         case (to_ff)
            TO_IDLE: if (to_mode_ff && btn_rise) to_ff <= TO_MEAS;
            TO_MEAS: if (meas_done) to_ff <= TO_SEND;
            TO_SEND: if (tx_done) begin
               to_ff    <= TO_FLASH;
               flash_ff <= '0;
            end
            TO_FLASH: begin
               flash_ff <= flash_ff + 25'h1;
               if (flash_ff == 25'(FLASH_CYCLES - 1)) to_ff <= TO_IDLE;
            end
            default: to_ff <= TO_IDLE;
         endcase
      end
   end

   // Transmit byte holder, loaded by software, serial poll or measurement.
   logic wb_req, wb_wr, wb_rd, poll_load;
   assign wb_req    = wb_cyc & wb_stb & ~ack_ff;
   assign wb_wr     = wb_cyc & wb_stb & ack_ff & wb_we & wb_sel[0]; // Lands at the edge the master sees ack.
   assign wb_rd     = wb_req & ~wb_we;
   assign poll_load = spe_ff & tad_ff & ~atn_s & ~tx_pend_ff;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_byte_ff <= '0;
         tx_eoi_ff  <= 1'b0;
         tx_pend_ff <= 1'b0;
         tx_poll_ff <= 1'b0;
      end else if (dev_clr || ifc_s) begin
         tx_pend_ff <= 1'b0;
      end else if (tx_done) begin
         tx_pend_ff <= 1'b0;
      end else if (!tx_pend_ff) begin
         if (to_mode_ff && to_ff == TO_MEAS && meas_done) begin
            tx_byte_ff <= meas_data;
            tx_eoi_ff  <= 1'b1;
            tx_pend_ff <= 1'b1;
            tx_poll_ff <= 1'b0;
         end else if (poll_load) begin
            tx_byte_ff <= {1'b0, stb_ff};
            tx_eoi_ff  <= 1'b0;
            tx_pend_ff <= 1'b1;
            tx_poll_ff <= 1'b1;
         end else if (wb_wr && wb_adr == A_TXD && !spe_ff && !to_mode_ff) begin
            tx_byte_ff <= wb_dat_w[7:0];
            tx_eoi_ff  <= wb_dat_w[TXD_EOI];
            tx_pend_ff <= 1'b1;
            tx_poll_ff <= 1'b0;
         end
      end
   end

   // Source handshake: settle, wait all ready, assert valid, wait accepted.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sh_ff     <= SH_IDLE;
         settle_ff <= '0;
      end else if (!talk_ok) begin
         sh_ff <= SH_IDLE;
      end else begin
         case (sh_ff)
            SH_IDLE: if (tx_pend_ff) begin
               sh_ff     <= SH_SETTLE;
               settle_ff <= '0;
            end
            SH_SETTLE: begin
               settle_ff <= settle_ff + 9'h1;
               if (settle_ff == 9'(SETTLE_CYC - 1)) sh_ff <= SH_WAIT;
            end
            SH_WAIT: if (!rfd_s && dac_s) sh_ff <= SH_DAV;
            SH_DAV: if (!dac_s) sh_ff <= SH_IDLE;
            default: sh_ff <= SH_IDLE;
         endcase
      end
   end

   // Status byte: software bits and request, error bit set by bad commands.
   logic dstat_rd;
   assign dstat_rd = wb_rd & (wb_adr == A_DSTAT);
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stb_ff <= '0;
      end else begin
         if (wb_wr && wb_adr == A_STB) stb_ff[5:1] <= wb_dat_w[5:1];
         if (wb_wr && wb_adr == A_STB && wb_dat_w[STB_RSV]) stb_ff[STB_RSV] <= 1'b1;
         else if (tx_done && tx_poll_ff) stb_ff[STB_RSV] <= 1'b0;
         if (parse_err) stb_ff[STB_ERR] <= 1'b1;
         else if (dstat_rd) stb_ff[STB_ERR] <= 1'b0;
      end
   end

   // Wishbone read data; unmapped addresses read as zero.
   always_comb begin
      nxt_dat_r = '0;
      if (wb_adr[A_SLOT_BIT]) begin
         if (wb_adr[6:2] < 5'(NUM_CAT)) nxt_dat_r[7:0] = slot_ff[wb_adr[6:2]];
      end else begin
         case (wb_adr)
            A_STAT:  nxt_dat_r[13:0] = {to_ff == TO_IDLE, tx_pend_ff, spe_ff, tad_ff, lad_ff,
                                        lockout_ff, remote_ff, to_mode_ff, cfg_done_ff, addr_ff};
            A_TXD:   nxt_dat_r[TXD_EOI:0] = {tx_eoi_ff, tx_byte_ff};
            A_DSTAT: nxt_dat_r[8:0] = {err_char_ff, stb_ff[STB_ERR]};
            A_STB:   nxt_dat_r[6:0] = stb_ff;
            default: nxt_dat_r = '0;
         endcase
      end
   end

   // Acknowledge one cycle after the request; data registered with it.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ack_ff   <= 1'b0;
         dat_r_ff <= '0;
      end else begin
         ack_ff <= wb_req;
         if (wb_rd) dat_r_ff <= nxt_dat_r;
      end
   end

   // Pin drivers: open drain, enable pulls the line to its true level.
   logic drive;
   assign drive = (sh_ff != SH_IDLE);
   for (genvar i = 0; i < 8; i++) begin : g_dio
      assign dio_oe[i] = drive & tx_byte_ff[i];
   end
   assign dio_out     = '0;
   assign dav_n_out   = 1'b0;
   assign dav_n_oe    = (sh_ff == SH_DAV);
   assign eoi_n_out   = 1'b0;
   assign eoi_n_oe    = drive & tx_eoi_ff;
   assign nrfd_n_out  = 1'b0;
   assign nrfd_n_oe   = (ah_ff == AH_HOLD);
   assign ndac_n_out  = 1'b0;
   assign ndac_n_oe   = (ah_ff == AH_READY);
   assign srq_n_out   = 1'b0;
   assign srq_n_oe    = stb_ff[STB_RSV];
   assign wb_ack      = ack_ff;
   assign wb_dat_r    = dat_r_ff;
   assign meas_start  = meas_start_ff;
   assign led_remote  = remote_ff;
   assign led_listen  = lad_ff | (to_ff == TO_FLASH);
   assign led_talk    = to_mode_ff | tad_ff;
   assign led_lockout = lockout_ff;
   assign btn_enable  = ~lockout_ff;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   // Checks on the block's outputs and internal state.
   property p_talk_only; to_mode_ff |-> led_talk; endproperty
   a_talk_only: assert property (p_talk_only) else $error("talk led off in talker-only");
   property p_dio_quiet; (dio_oe != 8'h0) |-> (to_mode_ff || (tad_ff && !atn_s)); endproperty
   a_dio_quiet: assert property (p_dio_quiet) else $error("data driven while not talker");
   property p_dav_ready; $rose(dav_n_oe) |-> $past(!rfd_s && dac_s); endproperty
   a_dav_ready: assert property (p_dav_ready) else $error("valid asserted before ready");
   property p_err_set; parse_err |=> stb_ff[STB_ERR]; endproperty
   a_err_set: assert property (p_err_set) else $error("error bit not set");
   property p_err_clr; (dstat_rd && !parse_err) |=> !stb_ff[STB_ERR]; endproperty
   a_err_clr: assert property (p_err_clr) else $error("error bit not cleared");
   property p_lock; lockout_ff |-> (!btn_enable && !btn_rise); endproperty
   a_lock: assert property (p_lock) else $error("buttons live under lockout");
   property p_ren_drop; !ren_s |=> (!remote_ff && !lockout_ff); endproperty
   a_ren_drop: assert property (p_ren_drop) else $error("remote kept without enable");
   property p_addr; cfg_done_ff |-> (addr_ff != ADDR_CTRL); endproperty
   a_addr: assert property (p_addr) else $error("address zero in use");
   property p_cfg_hold; cfg_done_ff |=> $stable(to_mode_ff) && $stable(addr_ff); endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("switch settings changed");
   property p_get; got_get |=> meas_start; endproperty
   a_get: assert property (p_get) else $error("trigger did not start measurement");
   property p_ah_hold; (ah_ff == AH_HOLD) && !dav_s |=> (ah_ff == AH_READY) || !ah_act; endproperty
   a_ah_hold: assert property (p_ah_hold) else $error("acceptor stuck in hold");
endmodule

// file: verif/gdp_ctl.sv
`timescale 1ns/10ps
module gdp_ctl (
   input  wire logic       clock,
   input  wire logic [7:0] dio_n,
   input  wire logic       dav_n,
   input  wire logic       nrfd_n,
   input  wire logic       ndac_n,
   input  wire logic       eoi_n,
   output logic      [7:0] c_dio,
   output logic            c_dav,
   output logic            c_nrfd,
   output logic            c_ndac,
   output logic            atn_n
);
   // All pulls start released; a released line floats high through the bus pull-ups.
   initial begin
      c_dio  = 8'h00;
      c_dav  = 1'b0;
      c_nrfd = 1'b0;
      c_ndac = 1'b0;
      atn_n  = 1'b1;
   end

   // Source one byte, waiting on the acceptor at both handshake steps.
   task automatic put(input logic [7:0] b, input logic atn);
      @(posedge clock);
      atn_n <= ~atn;
      c_dio <= b;
      repeat (4) @(posedge clock);
      do @(posedge clock); while (!nrfd_n);
      c_dav <= 1'b1;
      do @(posedge clock); while (!ndac_n);
      c_dav <= 1'b0;
      c_dio <= 8'h00;
   endtask

   // Accept one byte without any addressing, as a listen-only printer would.
   task automatic get(output logic [7:0] b, output logic e);
      @(posedge clock);
      atn_n  <= 1'b1;
      c_ndac <= 1'b1;
      do @(posedge clock); while (dav_n);
      b = ~dio_n;
      e = ~eoi_n;
      c_ndac <= 1'b0;
      do @(posedge clock); while (!dav_n);
   endtask
endmodule

// file: verif/gdp_port_tb.sv
`timescale 1ns/10ps
module gdp_port_tb;
   import gdp_pkg::*;
   localparam int FL = 32;
   logic        clock = 1'b0, rst_n = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
   logic [7:0]  wb_adr = 8'h00, cfg_sw = 8'h00, meas_data = 8'h00, m, b;
   logic [3:0]  wb_sel = 4'hf;
   logic [31:0] wb_dat_w = 32'h0, wb_dat_r, q;
   logic        ren_n = 1'b1, button = 1'b0, meas_done = 1'b0, wb_ack, e, atn_n;
   logic [7:0]  dio_oe, c_dio;
   logic        dav_n_oe, nrfd_n_oe, ndac_n_oe, eoi_n_oe, srq_n_oe, c_dav, c_nrfd, c_ndac;
   logic        meas_start, led_remote, led_listen, led_talk, led_lockout, btn_enable;
   wire  [7:0]  dio_in = ~(dio_oe | c_dio);
   wire         dav_n_in = ~(dav_n_oe | c_dav), nrfd_n_in = ~(nrfd_n_oe | c_nrfd);
   wire         ndac_n_in = ~(ndac_n_oe | c_ndac), eoi_n_in = ~eoi_n_oe;
   int          err_total = 0, n_compared = 0, n_start = 0, s0, slot[26];

   gdp_port #(.FLASH_CYCLES(FL)) i_gdp_port (.clock, .rst_n, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel,
      .wb_dat_w, .wb_dat_r, .wb_ack, .dio_in, .dio_out(), .dio_oe, .dav_n_in, .dav_n_out(), .dav_n_oe,
      .nrfd_n_in, .nrfd_n_out(), .nrfd_n_oe, .ndac_n_in, .ndac_n_out(), .ndac_n_oe, .eoi_n_in,
      .eoi_n_out(), .eoi_n_oe, .atn_n, .ifc_n(1'b1), .ren_n, .srq_n_out(), .srq_n_oe, .cfg_sw, .button,
      .meas_start, .meas_done, .meas_data, .led_remote, .led_listen, .led_talk, .led_lockout, .btn_enable);
   gdp_ctl i_gdp_ctl (.clock, .dio_n(dio_in), .dav_n(dav_n_in), .nrfd_n(nrfd_n_in), .ndac_n(ndac_n_in),
      .eoi_n(eoi_n_in), .c_dio, .c_dav, .c_nrfd, .c_ndac, .atn_n);

   // Clock and a count of measurement start pulses.
   always #2.5 clock = ~clock;
   always @(posedge clock) if (meas_start === 1'b1) n_start++;

   task automatic chk(input string s, input logic [31:0] x, input logic [31:0] y);
      n_compared++;
      if (y !== x) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", s, x, y);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      wb_cyc   <= 1'b1;
      wb_stb   <= 1'b1;
      wb_we    <= w;
      wb_adr   <= a;
      wb_dat_w <= d;
      do @(posedge clock); while (wb_ack !== 1'b1);
      q = wb_dat_r;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rst(input logic [7:0] c);
      @(posedge clock);
      rst_n  <= 1'b0;
      cfg_sw <= c;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      repeat (12) @(posedge clock);
   endtask
   // Sends letter and option pairs and keeps the last option of each letter.
   task automatic str(input string s);
      for (int i = 0; i < s.len(); i += 2) begin
         i_gdp_ctl.put(s[i], 1'b0);
         i_gdp_ctl.put(s[i+1], 1'b0);
         if (s[i] inside {[CH_A:CH_Z], [CH_LA:CH_LZ]}) slot[(s[i] | CH_CASE) - CH_LA] = s[i+1] | CH_CASE;
      end
   endtask
   task automatic slots;
      for (int i = 0; i < 26; i++) begin
         wb(1'b0, 8'(128 + 4 * i), 32'h0);
         chk("slot", slot[i], q[7:0]);
      end
   endtask
   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Watchdog against a stalled handshake.
   initial begin
      #400000;
      err_total++;
      summarize;
   end

   // Main sequence: switches, listener parsing, talker, talker-only.
   initial begin
      void'($urandom(87));
      foreach (slot[i]) slot[i] = 0;
      rst(8'hf9);
      wb(1'b0, A_STAT, 32'h0);
      chk("stat", 7'h26, q[6:0]);
      cfg_sw <= 8'h71;
      wb(1'b0, A_STAT, 32'h0);
      chk("stat", 7'h26, q[6:0]);
      rst(8'h71);
      wb(1'b0, A_STAT, 32'h0);
      chk("stat", 7'h31, q[6:0]);
      $display("test switches done");
      ren_n <= 1'b0;
      i_gdp_ctl.put(8'h31, 1'b1);
      @(posedge clock);
      chk("remote", 1, led_remote);
      chk("listen", 1, led_listen);
      str("Ab");
      i_gdp_ctl.put({1'b0, CMD_UNL}, 1'b1);
      i_gdp_ctl.put(8'h31, 1'b1);
      str("aC1x");
      slots;
      wb(1'b0, A_DSTAT, 32'h0);
      chk("dstat", 9'h063, q[8:0]);
      wb(1'b0, A_DSTAT, 32'h0);
      chk("dstat", 9'h062, q[8:0]);
      s0 = n_start;
      i_gdp_ctl.put({1'b0, CMD_GET}, 1'b1);
      repeat (10) @(posedge clock);
      chk("trigger", s0 + 1, n_start);
      i_gdp_ctl.put({1'b0, CMD_LLO}, 1'b1);
      repeat (10) @(posedge clock);
      chk("lockout", 2'b10, {led_lockout, btn_enable});
      i_gdp_ctl.put({1'b0, CMD_GTL}, 1'b1);
      repeat (2) @(posedge clock);
      chk("local", 2'b01, {led_remote, led_lockout});
      i_gdp_ctl.put({1'b0, CMD_DCL}, 1'b1);
      foreach (slot[i]) slot[i] = 0;
      slots;
      wb(1'b1, A_STB, 32'h40);
      chk("srq", 1, srq_n_oe);
      $display("test listener done");
      m = $urandom;
      wb(1'b1, A_TXD, {23'h0, 1'b1, m});
      i_gdp_ctl.put({1'b0, CMD_UNL}, 1'b1);
      repeat (500) @(posedge clock);
      chk("idle_bus", 8'h00, dio_oe);
      i_gdp_ctl.put(8'h51, 1'b1);
      i_gdp_ctl.get(b, e);
      chk("tx_byte", {1'b1, m}, {e, b});
      i_gdp_ctl.put({1'b0, CMD_SPE}, 1'b1);
      i_gdp_ctl.get(b, e);
      chk("poll", 9'h040, {e, b});
      chk("srq_clr", 0, srq_n_oe);
      $display("test talker done");
      rst(8'h70);
      wb(1'b0, A_STAT, 32'h0);
      chk("stat", 8'hf1, {led_talk, q[6:0]});
      s0 = n_start;
      for (int k = 0; k < 2; k++) begin
         m = $urandom;
         button <= 1'b1;
         for (int t = 0; t < 50 && n_start == s0 + k; t++) @(posedge clock);
         button    <= 1'b0;
         meas_data <= m;
         meas_done <= 1'b1;
         @(posedge clock);
         meas_done <= 1'b0;
         i_gdp_ctl.get(b, e);
         chk("to_byte", {1'b1, m}, {e, b});
         repeat (4) @(posedge clock);
         chk("flash", 1, led_listen);
         repeat (FL + 8) @(posedge clock);
         chk("flash", 2'b01, {led_listen, led_talk});
      end
      chk("starts", s0 + 2, n_start);
      $display("test talker_only done");
      summarize;
   end
endmodule
